// ===== logic/ethernet_wakeup_detector.sv
// Wakeup manager: power-down control, remote pattern and station packets
//
// The register addresses and the AHB-Lite slave port were chosen for this implementation.
`timescale 1ns/100ps
`include "wakeup_cfg.svh"
// Summary of operation
// - Power-down discards received frame data
// - Detection advances only on receive clock
// - Wakeup sets its flag and leaves power-down
// - Pattern filters active only in enabled power-down
// - Needs address pass and CRC-16 match
// - Long frames accepted if FCS good
// - Remote hit sets flag, unmasked interrupt
// - Station packet sets flag, enabled interrupt
// - Eight entries behind one auto-incrementing port
// - Mask bits 30..0 pick bytes, 31 zero
// - Command bit3 multicast, bit0 enable
// - Offset is first byte, at least 12; lower offsets are applied as written
// - Each filter holds 16-bit reference CRC
// - Entry order masks, commands, offsets, CRCs
// - Status read clears event flags
// - Two wake types, separately enabled
module ethernet_wakeup_detector
   import wakeup_pkg::*;
(
   input  wire logic        sys_clk,
   input  wire logic        arst_n,
   input  wire logic        ce,
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic      [31:0] hrdata,
   output logic             hreadyout,
   output logic             hresp,
   input  wire logic        rxClk,
   input  wire logic        rxDv,
   input  wire logic        rxEr,
   input  wire logic [3:0]  rxd,
   output logic      [7:0]  rxData,
   output logic             rxDataValid,
   output logic             powerDown,
   output logic             wakeIrq
);
   localparam int NF = `WK_FILTERS;

   function automatic logic [15:0] crc16Step(input logic [15:0] c,
                                             input logic [7:0]  d);
      logic [15:0] r;
      r = c;
      for (int i = 0; i < 8; i++) begin
         r = (r[0] ^ d[i]) ? ((r >> 1) ^ `WK_CRC16_POLY) : (r >> 1);
      end
      return r;
   endfunction : crc16Step

   function automatic logic [31:0] crc32Step(input logic [31:0] c,
                                             input logic [7:0]  d);
      logic [31:0] r;
      r = c;
      for (int i = 0; i < 8; i++) begin
         r = (r[0] ^ d[i]) ? ((r >> 1) ^ `WK_CRC32_POLY) : (r >> 1);
      end
      return r;
   endfunction : crc32Step

   rx_byte_type   rxb;
   ctrl_type      ctrl,      next_ctrl;
   filter_type    filt[NF];
   filter_type    next_filt[NF];
   logic [47:0]   stAddr,    next_stAddr;
   logic [2:0]    ptr,       next_ptr;
   bus_state_type busState,  next_busState;
   logic [1:0]    regIdx,    next_regIdx;
   logic          mapped,    next_mapped;
   logic [31:0]   next_hrdata;
   logic          next_hreadyout;
   logic          next_wakeIrq;
   logic          accept;
   logic [31:0]   entryVal;
   logic [31:0]   ctrlImage;

   mii_rx_sampler sampler (
      .sys_clk (sys_clk),
      .arst_n  (arst_n),
      .ce      (ce),
      .rxClk   (rxClk),
      .rxDv    (rxDv),
      .rxEr    (rxEr),
      .rxd     (rxd),
      .rxByte  (rxb)
   );

   // Frame-side state
   logic [15:0] byteIdx,   next_byteIdx;
   logic [31:0] fcs,       next_fcs;
   logic        daUni,     next_daUni;
   logic        mcast,     next_mcast;
   logic [15:0] fcrc[NF];
   logic [15:0] next_fcrc[NF];
   logic [2:0]  ffCnt,     next_ffCnt;
   logic [2:0]  aIdx,      next_aIdx;
   logic [4:0]  copies,    next_copies;
   logic        patternSeen, next_patternSeen;
   logic        wakeRemote, next_wakeRemote;
   logic        wakeStation, next_wakeStation;
   logic [7:0]  next_rxData;
   logic        next_rxDataValid;
   logic        remoteArmed;
   logic [15:0] rel;
   logic        addrPass;

   assign accept = hsel && htrans[1] && hready;

   always_comb begin
      unique case (ptr)
         `WK_ENTRY_CMD:
            entryVal = {4'h0, filt[3].cmd, 4'h0, filt[2].cmd,
                        4'h0, filt[1].cmd, 4'h0, filt[0].cmd};
         `WK_ENTRY_OFFSET:
            entryVal = {filt[3].offset, filt[2].offset,
                        filt[1].offset, filt[0].offset};
         `WK_ENTRY_CRC_LO: entryVal = {filt[1].crc, filt[0].crc};
         `WK_ENTRY_CRC_HI: entryVal = {filt[3].crc, filt[2].crc};
         default:          entryVal = {1'b0, filt[ptr[1:0]].mask};
      endcase
      ctrlImage = 32'h0000_0000;
      ctrlImage[`WK_BIT_PD]          = ctrl.pd;
      ctrlImage[`WK_BIT_STATION_EN]  = ctrl.stationEn;
      ctrlImage[`WK_BIT_REMOTE_EN]   = ctrl.remoteEn;
      ctrlImage[`WK_BIT_REMOTE_MASK] = ctrl.remoteMask;
      ctrlImage[`WK_BIT_STATION_IE]  = ctrl.stationIe;
      ctrlImage[`WK_BIT_STATION_FLG] = ctrl.stationFlag;
      ctrlImage[`WK_BIT_REMOTE_FLG]  = ctrl.remoteFlag;
      ctrlImage[`WK_POS_POINTER +: 3] = ptr;
   end

   // Register side: zero-wait writes, one wait state on reads
   always_comb begin
      next_ctrl      = ctrl;
      next_filt      = filt;
      next_stAddr    = stAddr;
      next_ptr       = ptr;
      next_busState  = BUS_IDLE;
      next_regIdx    = regIdx;
      next_mapped    = mapped;
      next_hrdata    = hrdata;
      next_hreadyout = 1'b1;
      unique case (busState)
         BUS_WRITE: begin
            if (mapped) begin
               unique case (regIdx)
                  2'h0: begin
                     next_ctrl.pd         = hwdata[`WK_BIT_PD];
                     next_ctrl.stationEn  = hwdata[`WK_BIT_STATION_EN];
                     next_ctrl.remoteEn   = hwdata[`WK_BIT_REMOTE_EN];
                     next_ctrl.remoteMask = hwdata[`WK_BIT_REMOTE_MASK];
                     next_ctrl.stationIe  = hwdata[`WK_BIT_STATION_IE];
                  end
                  2'h1: begin
                     unique case (ptr)
                        `WK_ENTRY_CMD:
                           for (int i = 0; i < NF; i++)
                              next_filt[i].cmd = hwdata[8*i +: 4];
                        `WK_ENTRY_OFFSET:
                           for (int i = 0; i < NF; i++)
                              next_filt[i].offset = hwdata[8*i +: 8];
                        `WK_ENTRY_CRC_LO: begin
                           next_filt[0].crc = hwdata[15:0];
                           next_filt[1].crc = hwdata[31:16];
                        end
                        `WK_ENTRY_CRC_HI: begin
                           next_filt[2].crc = hwdata[15:0];
                           next_filt[3].crc = hwdata[31:16];
                        end
                        default:
                           next_filt[ptr[1:0]].mask = hwdata[30:0];
                     endcase
                     next_ptr = ptr + 3'h1;
                  end
                  2'h2: next_stAddr[31:0]  = hwdata;
                  2'h3: next_stAddr[47:32] = hwdata[15:0];
               endcase
            end
         end
         BUS_READ: begin
            next_hrdata = 32'h0000_0000;
            if (mapped) begin
               unique case (regIdx)
                  2'h0: begin
                     next_hrdata = ctrlImage;
                     next_ctrl.stationFlag = 1'b0;
                     next_ctrl.remoteFlag  = 1'b0;
                  end
                  2'h1: begin
                     next_hrdata = entryVal;
                     next_ptr    = ptr + 3'h1;
                  end
                  2'h2: next_hrdata = stAddr[31:0];
                  2'h3: next_hrdata = {16'h0000, stAddr[47:32]};
               endcase
            end
         end
         default: ;
      endcase
      if (accept) begin
         next_busState  = hwrite ? BUS_WRITE : BUS_READ;
         next_hreadyout = hwrite;
         next_mapped    = (haddr[31:12] == 20'h00000)
                          && (haddr[11:4] == 8'h00) && (haddr[1:0] == 2'h0);
         next_regIdx    = haddr[3:2];
      end
      // Hardware events win over a clearing read in the same cycle
      if (wakeRemote) begin
         next_ctrl.remoteFlag = 1'b1;
         next_ctrl.pd         = 1'b0;
      end
      if (wakeStation) begin
         next_ctrl.stationFlag = 1'b1;
         next_ctrl.pd          = 1'b0;
      end
      next_wakeIrq = (next_ctrl.remoteFlag && !next_ctrl.remoteMask)
                     || (next_ctrl.stationFlag && next_ctrl.stationIe);
   end

   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         ctrl      <= '0;
         filt      <= '{default: '0};
         stAddr    <= `WK_ADDR_RESET;
         ptr       <= 3'h0;
         busState  <= BUS_IDLE;
         regIdx    <= 2'h0;
         mapped    <= 1'b0;
         hrdata    <= 32'h0000_0000;
         hreadyout <= 1'b1;
         hresp     <= 1'b0;
         wakeIrq   <= 1'b0;
         powerDown <= 1'b0;
      end else if (ce) begin
         ctrl      <= next_ctrl;
         filt      <= next_filt;
         stAddr    <= next_stAddr;
         ptr       <= next_ptr;
         busState  <= next_busState;
         regIdx    <= next_regIdx;
         mapped    <= next_mapped;
         hrdata    <= next_hrdata;
         hreadyout <= next_hreadyout;
         hresp     <= 1'b0;
         wakeIrq   <= next_wakeIrq;
         powerDown <= next_ctrl.pd;
      end
   end

   // Frame side
   assign remoteArmed = ctrl.pd && ctrl.remoteEn;
   assign addrPass    = mcast || daUni;

   always_comb begin
      next_byteIdx     = byteIdx;
      next_fcs         = fcs;
      next_daUni       = daUni;
      next_mcast       = mcast;
      next_fcrc        = fcrc;
      next_ffCnt       = ffCnt;
      next_aIdx        = aIdx;
      next_copies      = copies;
      next_patternSeen = patternSeen;
      next_wakeRemote  = 1'b0;
      next_wakeStation = 1'b0;
      next_rxData      = rxData;
      next_rxDataValid = rxb.valid && !ctrl.pd;
      rel              = 16'h0000;
      if (rxb.valid) begin
         next_rxData = rxb.data;
         // Index saturates so long frames still complete
         if (byteIdx != 16'hFFFF)
            next_byteIdx = byteIdx + 16'h1;
         next_fcs = crc32Step(fcs, rxb.data);
         if (byteIdx == 16'h0000)
            next_mcast = rxb.data[0];
         if (byteIdx < 16'({13'h0, `WK_ADDR_BYTES}))
            next_daUni = daUni && (rxb.data == stAddr[8*byteIdx[2:0] +: 8]);
         for (int f = 0; f < NF; f++) begin
            rel = byteIdx - {8'h00, filt[f].offset};
            if (byteIdx >= {8'h00, filt[f].offset} && rel < `WK_MASK_BITS
                && filt[f].mask[rel[4:0]])
               next_fcrc[f] = crc16Step(fcrc[f], rxb.data);
         end
         // Station packet search
         if (ffCnt != `WK_SYNC_BYTES) begin
            next_ffCnt = (rxb.data == `WK_SYNC_BYTE) ? ffCnt + 3'h1 : 3'h0;
         end else if (rxb.data == stAddr[8*aIdx +: 8]) begin
            next_aIdx = aIdx + 3'h1;
            if (aIdx + 3'h1 == `WK_ADDR_BYTES) begin
               next_aIdx   = 3'h0;
               next_copies = copies + 5'h1;
               if (copies + 5'h1 == `WK_ADDR_COPIES)
                  next_patternSeen = 1'b1;
            end
         end else if (!(rxb.data == `WK_SYNC_BYTE && aIdx == 3'h0
                        && copies == 5'h00)) begin
            next_ffCnt  = (rxb.data == `WK_SYNC_BYTE) ? 3'h1 : 3'h0;
            next_aIdx   = 3'h0;
            next_copies = 5'h00;
         end
      end
      if (rxb.stop) begin
         if (!rxb.err && fcs == `WK_CRC32_RESIDUE) begin
            for (int f = 0; f < NF; f++)
               if (remoteArmed && filt[f].cmd[`WK_CMD_ENABLE] && addrPass
                   && (filt[f].cmd[`WK_CMD_MCAST] ? mcast : daUni)
                   && fcrc[f] == filt[f].crc)
                  next_wakeRemote = 1'b1;
            next_wakeStation = ctrl.pd && ctrl.stationEn
                               && patternSeen;
         end
         next_byteIdx   = 16'h0000;
         next_fcs       = `WK_CRC32_INIT;
         next_daUni     = 1'b1;
         next_mcast     = 1'b0;
         next_fcrc      = '{default: `WK_CRC16_INIT};
         next_ffCnt     = 3'h0;
         next_aIdx      = 3'h0;
         next_copies    = 5'h00;
         next_patternSeen = 1'b0;
      end
   end

   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         byteIdx     <= 16'h0000;
         fcs         <= `WK_CRC32_INIT;
         daUni       <= 1'b1;
         mcast       <= 1'b0;
         fcrc        <= '{default: `WK_CRC16_INIT};
         ffCnt       <= 3'h0;
         aIdx        <= 3'h0;
         copies      <= 5'h00;
         patternSeen <= 1'b0;
         wakeRemote  <= 1'b0;
         wakeStation <= 1'b0;
         rxData      <= 8'h00;
         rxDataValid <= 1'b0;
      end else if (ce) begin
         byteIdx     <= next_byteIdx;
         fcs         <= next_fcs;
         daUni       <= next_daUni;
         mcast       <= next_mcast;
         fcrc        <= next_fcrc;
         ffCnt       <= next_ffCnt;
         aIdx        <= next_aIdx;
         copies      <= next_copies;
         patternSeen <= next_patternSeen;
         wakeRemote  <= next_wakeRemote;
         wakeStation <= next_wakeStation;
         rxData      <= next_rxData;
         rxDataValid <= next_rxDataValid;
      end
   end

   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!arst_n || !ce);

   pd_discard_a: assert property (powerDown |=> !rxDataValid)
      else $error("frame data passed during power-down");
   remote_gate_a: assert property (wakeRemote
                                   |-> $past(remoteArmed))
      else $error("remote wake outside armed power-down");
   remote_flag_a: assert property (wakeRemote
                                   |=> ctrl.remoteFlag && !powerDown)
      else $error("remote wake did not set flag or exit");
   station_flag_a: assert property (wakeStation
                                    |=> ctrl.stationFlag)
      else $error("station wake did not set flag");
   wake_irq_a: assert property (wakeRemote && !ctrl.remoteMask
                                |=> wakeIrq)
      else $error("unmasked wake raised no interrupt");
   pointer_step_a: assert property (busState == BUS_READ && mapped
                                    && regIdx == 2'h1 && !accept
                                    |=> ptr == $past(ptr) + 3'h1)
      else $error("filter pointer did not advance");
   read_clear_a: assert property (busState == BUS_READ && mapped
                                  && regIdx == 2'h0 && !wakeRemote
                                  && !wakeStation |=> !ctrl.remoteFlag
                                  && !ctrl.stationFlag)
      else $error("status read did not clear flags");
   read_wait_a: assert property (accept && !hwrite
                                 |=> !hreadyout ##1 hreadyout)
      else $error("read answer timing wrong");
   pd_clear_a: assert property (wakeStation |=> !ctrl.pd)
      else $error("power-down not cleared on wake");
endmodule : ethernet_wakeup_detector

// ===== logic/wakeup_cfg.svh
// Offsets, bit positions, reset values and link constants of the wakeup block
`ifndef WAKEUP_CFG_SVH
`define WAKEUP_CFG_SVH
`define WK_OFS_CTRL        12'h000
`define WK_OFS_FILTER      12'h004
`define WK_OFS_ADDR_LO     12'h008
`define WK_OFS_ADDR_HI     12'h00C
`define WK_BIT_PD          0
`define WK_BIT_STATION_EN  1
`define WK_BIT_REMOTE_EN   2
`define WK_BIT_REMOTE_MASK 3
`define WK_BIT_STATION_IE  4
`define WK_BIT_STATION_FLG 5
`define WK_BIT_REMOTE_FLG  6
`define WK_POS_POINTER     24
`define WK_CMD_MCAST       3
`define WK_CMD_ENABLE      0
`define WK_FILTERS         4
`define WK_ENTRIES         8
`define WK_MASK_BITS       31
`define WK_ENTRY_CMD       3'h4
`define WK_ENTRY_OFFSET    3'h5
`define WK_ENTRY_CRC_LO    3'h6
`define WK_ENTRY_CRC_HI    3'h7
`define WK_ADDR_RESET      48'h0000_0000_0000
`define WK_SFD_NIBBLE      4'hD
`define WK_SYNC_BYTE       8'hFF
`define WK_SYNC_BYTES      3'h6
`define WK_ADDR_BYTES      3'h6
`define WK_ADDR_COPIES     5'h10
`define WK_CRC16_POLY      16'hA001
`define WK_CRC16_INIT      16'hFFFF
`define WK_CRC32_POLY      32'hEDB8_8320
`define WK_CRC32_INIT      32'hFFFF_FFFF
`define WK_CRC32_RESIDUE   32'hDEBB_20E3
`endif

// ===== logic/wakeup_pkg.sv
// Types shared by the wakeup detector and its receive sampler
package wakeup_pkg;
   typedef struct packed {
      logic       valid;
      logic       stop;
      logic       err;
      logic [7:0] data;
   } rx_byte_type;

   typedef struct packed {
      logic [30:0] mask;
      logic [3:0]  cmd;
      logic [7:0]  offset;
      logic [15:0] crc;
   } filter_type;

   typedef struct packed {
      logic pd;
      logic stationEn;
      logic remoteEn;
      logic remoteMask;
      logic stationIe;
      logic stationFlag;
      logic remoteFlag;
   } ctrl_type;

   typedef enum logic [1:0] {BUS_IDLE, BUS_WRITE, BUS_READ} bus_state_type;
endpackage : wakeup_pkg

// ===== logic/mii_rx_sampler.sv
// Synchronises MII receive pins and assembles nibbles into bytes
`timescale 1ns/100ps
`include "wakeup_cfg.svh"
module mii_rx_sampler
   import wakeup_pkg::*;
(
   input  wire logic       sys_clk,
   input  wire logic       arst_n,
   input  wire logic       ce,
   input  wire logic       rxClk,
   input  wire logic       rxDv,
   input  wire logic       rxEr,
   input  wire logic [3:0] rxd,
   output rx_byte_type     rxByte
);
   logic [6:0]  syncA;
   logic [6:0]  syncB;
   logic        clkLast;
   logic        inFrame;
   logic        half;
   logic        errSeen;
   logic [3:0]  lowNib;
   logic        next_inFrame;
   logic        next_half;
   logic        next_errSeen;
   logic [3:0]  next_lowNib;
   rx_byte_type next_rxByte;

   always_comb begin
      next_inFrame = inFrame;
      next_half    = half;
      next_errSeen = errSeen;
      next_lowNib  = lowNib;
      next_rxByte  = '{valid: 1'b0, stop: 1'b0, err: errSeen,
                       data: rxByte.data};
      // Work happens only on a receive clock edge
      if (syncB[6] && !clkLast) begin
         if (syncB[5]) begin
            if (!inFrame) begin
               if (syncB[3:0] == `WK_SFD_NIBBLE) begin
                  next_inFrame = 1'b1;
                  next_half    = 1'b0;
                  next_errSeen = 1'b0;
               end
            end else begin
               next_errSeen = errSeen | syncB[4];
               if (!half) begin
                  next_lowNib = syncB[3:0];
                  next_half   = 1'b1;
               end else begin
                  next_rxByte.valid = 1'b1;
                  next_rxByte.data  = {syncB[3:0], lowNib};
                  next_half         = 1'b0;
               end
            end
         end else if (inFrame) begin
            // A dangling nibble marks the frame as bad
            next_rxByte.stop = 1'b1;
            next_rxByte.err  = errSeen | half;
            next_inFrame     = 1'b0;
         end
      end
   end

   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         syncA   <= 7'h00;
         syncB   <= 7'h00;
         clkLast <= 1'b0;
         inFrame <= 1'b0;
         half    <= 1'b0;
         errSeen <= 1'b0;
         lowNib  <= 4'h0;
         rxByte  <= '0;
      end else if (ce) begin
         syncA   <= {rxClk, rxDv, rxEr, rxd};
         syncB   <= syncA;
         clkLast <= syncB[6];
         inFrame <= next_inFrame;
         half    <= next_half;
         errSeen <= next_errSeen;
         lowNib  <= next_lowNib;
         rxByte  <= next_rxByte;
      end
   end
endmodule : mii_rx_sampler

// ===== dv/mii_phy_model.sv
// Behavioural PHY that plays frames onto the MII receive pins
`timescale 1ns/100ps
module mii_phy_model (
   output logic       rxClk,
   output logic       rxDv,
   output logic       rxEr,
   output logic [3:0] rxd
);
   initial begin
      rxClk = 1'b0;
      rxDv  = 1'b0;
      rxEr  = 1'b0;
      rxd   = 4'hA;
   end
   // Idle data toggles so a stale nibble never looks valid
   task automatic tick(input logic v, input logic [3:0] n);
      rxClk = 1'b0;
      rxDv  = v;
      rxd   = v ? n : ~rxd;
      #400;
      rxClk = 1'b1;
      #400;
   endtask : tick
   // Clock runs only around a frame; low nibble of a byte first
   task automatic send(input logic [7:0] f[$]);
      #37;
      repeat (15) tick(1'b1, 4'h5);
      tick(1'b1, 4'hD);
      foreach (f[i]) begin
         tick(1'b1, f[i][3:0]);
         tick(1'b1, f[i][7:4]);
      end
      repeat (2) tick(1'b0, 4'h0);
      rxClk = 1'b0;
   endtask : send
endmodule : mii_phy_model

// ===== dv/ethernet_wakeup_detector_bench.sv
// Bench: register access, filter port and both wake paths
`timescale 1ns/100ps
`include "wakeup_cfg.svh"
`define CHK(n, e, g) begin nChecks++; if ((g) !== (e)) begin nFail++; \
$display("BAD %s exp %h got %h", n, e, g); end end
module ethernet_wakeup_detector_bench
   import wakeup_pkg::*;
;
   logic        sys_clk, hreadyout, hresp, rxClk, rxDv, rxEr;
   logic        rxDataValid, powerDown, wakeIrq;
   logic        arst_n = 1'b0;
   logic        hwrite = 1'b0;
   logic [1:0]  htrans = 2'h0;
   logic [3:0]  rxd;
   logic [7:0]  rxData;
   logic [31:0] haddr = 32'h0;
   logic [31:0] hwdata = 32'h0;
   logic [31:0] hrdata, q, fc[8];
   logic [7:0]  fr[$];
   logic [7:0]  sta[6] = '{8'h11, 8'h22, 8'h33, 8'h44, 8'h55, 8'h66};
   int          nFail = 0, nChecks = 0, nBytes = 0;

   ethernet_wakeup_detector u_dut (
      .sys_clk(sys_clk), .arst_n(arst_n), .ce(1'b1), .hsel(1'b1),
      .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
      .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
      .hreadyout(hreadyout), .hresp(hresp), .rxClk(rxClk), .rxDv(rxDv),
      .rxEr(rxEr), .rxd(rxd), .rxData(rxData), .rxDataValid(rxDataValid),
      .powerDown(powerDown), .wakeIrq(wakeIrq));
   mii_phy_model u_phy (.rxClk(rxClk), .rxDv(rxDv), .rxEr(rxEr), .rxd(rxd));

   initial begin
      sys_clk = 1'b0;
      forever #50 sys_clk = ~sys_clk;
   end

   task complete_run;
      if (nFail == 0 && nChecks > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask : complete_run

   // Address phase held until hready, then data phase until hready
   task automatic bus(input logic w, input logic [31:0] a, d);
      htrans <= 2'h2;
      haddr  <= a;
      hwrite <= w;
      @(posedge sys_clk iff hreadyout === 1'b1);
      htrans <= 2'h0;
      hwdata <= d;
      @(posedge sys_clk iff hreadyout === 1'b1);
      q = hrdata;
      `CHK("hresp", 1'b0, hresp)
   endtask : bus

   task automatic rd(input logic [31:0] a, e, input string n);
      bus(1'b0, a, 32'h0);
      `CHK(n, e, q)
   endtask : rd

   function automatic logic [31:0] crc(logic [31:0] c, p, logic [7:0] d);
      c = c ^ {24'h0, d};
      repeat (8) c = c[0] ? (c >> 1) ^ p : c >> 1;
      return c;
   endfunction : crc

   // Appends the FCS, a wrong one on request, and plays the frame
   task automatic play(input logic good);
      logic [31:0] c;
      c = `WK_CRC32_INIT;
      foreach (fr[i]) c = crc(c, `WK_CRC32_POLY, fr[i]);
      c = ~c ^ {31'h0, !good};
      for (int i = 0; i < 4; i++) fr.push_back(c[8*i +: 8]);
      nBytes = 0;
      u_phy.send(fr);
      repeat (4) @(posedge sys_clk);
   endtask : play

   // Pattern byte sits at frame position 14, byte 0 is the given DA byte, the rest is filler
   task automatic remote(input int len, input logic [7:0] da, input logic g);
      fr.delete();
      for (int i = 0; i < len; i++)
         fr.push_back(i == 0 ? da : i == 14 ? 8'h5A : i > 5 ? 8'h02 : 8'h00);
      play(g);
   endtask : remote

   task automatic station();
      fr.delete();
      foreach (sta[i]) fr.push_back(sta[i]);
      for (int i = 0; i < 8; i++) fr.push_back(i < 6 ? 8'h02 : 8'h08);
      repeat (6) fr.push_back(8'hFF);
      repeat (16) foreach (sta[i]) fr.push_back(sta[i]);
      play(1'b1);
   endtask : station

   always @(posedge sys_clk) begin
      if (rxDataValid === 1'b1) begin
         nBytes++;
         `CHK("pd", 1'b0, powerDown)
      end
   end

   initial begin
      repeat (40000) @(posedge sys_clk);
      nFail++;
      complete_run();
   end

   initial begin
      fc = '{32'h8000_0001, 32'h1234_5678, 32'hFFFF_FFFF, 32'h0000_0002,
             32'h0000_0809, 32'h0F0E_0D0E, 32'hC0DE_0000, 32'hBEEF_0000};
      fc[6] = fc[6] | crc({16'h0, `WK_CRC16_INIT}, `WK_CRC16_POLY, 8'h5A);
      repeat (16) @(posedge sys_clk);
      arst_n <= 1'b1;
      @(posedge sys_clk);
      `CHK("irq", 1'b0, wakeIrq)
      rd(`WK_OFS_CTRL, 32'h0, "ctrl");
      bus(1'b1, `WK_OFS_ADDR_LO, 32'h4433_2211);
      bus(1'b1, `WK_OFS_ADDR_HI, 32'h0000_6655);
      rd(`WK_OFS_ADDR_HI, 32'h0000_6655, "addr");
      for (int i = 0; i < 8; i++)
         bus(1'b1, `WK_OFS_FILTER, fc[i]);
      for (int i = 0; i < 8; i++)
         rd(`WK_OFS_FILTER, fc[i] & {i > 3, 31'h7FFF_FFFF}, "f");
      bus(1'b1, 32'h10, 32'hFFFF_FFFF);
      rd(32'h10, 32'h0, "unmapped");
      bus(1'b1, `WK_OFS_CTRL, 32'h0000_0016);
      remote(64, 8'h01, 1'b1);
      `CHK("bytes", 68, nBytes)
      `CHK("rxData", fr[67], rxData)
      rd(`WK_OFS_CTRL, 32'h16, "ctrl");
      bus(1'b1, `WK_OFS_CTRL, 32'h0000_0004);
      bus(1'b1, `WK_OFS_CTRL, 32'h0000_0005);
      station();
      remote(64, 8'h00, 1'b1);
      remote(64, 8'h01, 1'b0);
      `CHK("pd", 1'b1, powerDown)
      remote(600, 8'h01, 1'b1);
      `CHK("pd", 1'b0, powerDown)
      `CHK("irq", 1'b1, wakeIrq)
      rd(`WK_OFS_CTRL, 32'h44, "ctrl");
      rd(`WK_OFS_CTRL, 32'h04, "ctrl");
      `CHK("irq", 1'b0, wakeIrq)
      bus(1'b1, `WK_OFS_CTRL, 32'h0000_000D);
      remote(64, 8'h01, 1'b1);
      `CHK("irq", 1'b0, wakeIrq)
      rd(`WK_OFS_CTRL, 32'h4C, "ctrl");
      bus(1'b1, `WK_OFS_CTRL, 32'h0000_0013);
      station();
      `CHK("pd", 1'b0, powerDown)
      `CHK("irq", 1'b1, wakeIrq)
      rd(`WK_OFS_CTRL, 32'h32, "ctrl");
      complete_run();
   end
endmodule : ethernet_wakeup_detector_bench
